// File: hw/vmcp_pkg.sv
// constants, encodings and types of the control-pointer instruction unit
// Operation
// - pointer load: escape group reg 6, memory operand only, else invalid
// - unaligned or too-wide load address fails, pointer kept
// - load address equal to enable-region pointer fails distinctly
// - revision word at load address must match supported revision
// - all checks passed: load pointer, mark valid, report success
// - with capability bit 48 set, any of bits 63:32 fails the load
// - segment errors give protection or stack fault; paging page fault
// - 64-bit non-canonical address: protection, or stack fault on stack
// - pointer store: escape group reg 7, writes current pointer
// - store to read-only or code segment faults; register is invalid
// - field read selects field by register encoding
// - encoding 32 bits outside long mode, 64 in 64-bit; high set fails
// - field read destination 32 bits outside long mode, else 64
// - narrow field zero-extended, wide field truncated to destination
// - memory destination faults only after pointer and field checks
// - launch and resume: mode invalid-opcode, privilege fault
// - unknown field encoding fails valid as unsupported component
package vmcp_pkg;
   localparam logic [7:0]  OPC_ESC_GRP   = 8'hC7;
   localparam logic [7:0]  OPC_FIELD_RD  = 8'h78;
   localparam logic [7:0]  OPC_LAUNCH    = 8'hC2;
   localparam logic [7:0]  OPC_RESUME    = 8'hC3;
   localparam logic [2:0]  REG_PTR_LOAD  = 3'h6;
   localparam logic [2:0]  REG_PTR_STORE = 3'h7;
   localparam logic [63:0] PTR_INVALID   = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam int          PAGE_BITS     = 12;
   localparam int          CAP_NARROW_BIT = 48;
   localparam int          ENC_WIDTH     = 32;
   // fault classes
   localparam logic [2:0]  FLT_NONE = 3'h0;
   localparam logic [2:0]  FLT_UD   = 3'h1;
   localparam logic [2:0]  FLT_GP   = 3'h2;
   localparam logic [2:0]  FLT_SS   = 3'h3;
   localparam logic [2:0]  FLT_PF   = 3'h4;
   localparam logic [2:0]  FLT_EXIT = 3'h5;
   // outcome classes
   localparam logic [1:0]  RES_OK       = 2'h0;
   localparam logic [1:0]  RES_FAIL_INV = 2'h1;
   localparam logic [1:0]  RES_FAIL_VAL = 2'h2;
   // failure error numbers
   localparam logic [7:0]  ERR_NONE     = 8'h00;
   localparam logic [7:0]  ERR_LD_ADDR  = 8'h09;
   localparam logic [7:0]  ERR_LD_ENPTR = 8'h0A;
   localparam logic [7:0]  ERR_LD_REV   = 8'h0B;
   localparam logic [7:0]  ERR_UNSUP    = 8'h0C;
   // memory access kinds
   localparam logic [1:0]  MEM_RD64 = 2'h0;
   localparam logic [1:0]  MEM_RD32 = 2'h1;
   localparam logic [1:0]  MEM_WR64 = 2'h2;
   localparam logic [1:0]  MEM_WRDST = 2'h3;
   // interrupt status bits
   localparam int          IRQ_DONE  = 0;
   localparam int          IRQ_FAULT = 1;
   localparam int          IRQ_FAIL  = 2;
   localparam int          IRQ_W     = 3;
   typedef enum logic [2:0] {
      VMCP_IDLE  = 3'b000,
      VMCP_OPRD  = 3'b001,
      VMCP_REVRD = 3'b011,
      VMCP_WRITE = 3'b010,
      VMCP_DONE  = 3'b110
   } vmcp_state_e;
endpackage

// File: hw/vmcp_unit.sv
// control-pointer load/store and field-read execution unit
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module vmcp_unit #(
   parameter int PA_WIDTH = 52,
   parameter logic [31:0] REV_ID = 32'h0000_0001 // arbitrary value
) (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // instruction issue
   input  wire logic        INSTR_VALID,
   input  wire logic [7:0]  INSTR_OPCODE,
   input  wire logic [2:0]  INSTR_REG,
   input  wire logic        INSTR_REG_OPND,
   input  wire logic [63:0] INSTR_FIELD_ENC,
   // processor mode state
   input  wire logic        VIRT_OP_ACTIVE,
   input  wire logic        GUEST_ACTIVE,
   input  wire logic        PROT_ENABLE,
   input  wire logic        V86_MODE,
   input  wire logic        LONG_MODE_ACTIVE,
   input  wire logic        CS_LONG,
   input  wire logic [1:0]  CUR_PRIV,
   input  wire logic [63:0] BASIC_CAP,
   input  wire logic [63:0] ENABLE_REGION_PTR,
   // segment and paging checks of the memory operand
   input  wire logic        SEG_LIMIT_ERR,
   input  wire logic        SEG_UNUSABLE,
   input  wire logic        SEG_IS_STACK,
   input  wire logic        SEG_EXEC_ONLY,
   input  wire logic        SEG_READ_ONLY,
   input  wire logic        SEG_IS_CODE,
   input  wire logic        ADDR_NONCANON,
   input  wire logic        PAGE_ERR,
   // field store lookup
   output logic [31:0]      FIELD_ENC,
   input  wire logic        FIELD_SUPPORTED,
   input  wire logic [63:0] FIELD_DATA,
   input  wire logic [6:0]  FIELD_WIDTH,
   // memory port
   output logic             MEM_REQ,
   output logic [1:0]       MEM_KIND,
   output logic [63:0]      MEM_WDATA,
   input  wire logic        MEM_ACK,
   input  wire logic [63:0] MEM_RDATA,
   // completion
   output logic             DONE,
   output logic [2:0]       FAULT,
   output logic [1:0]       RESULT,
   output logic [7:0]       ERR_NUM,
   output logic [63:0]      DEST_DATA,
   output logic             DEST_WE,
   output logic [63:0]      CUR_PTR,
   output logic             CUR_PTR_VALID,
   // register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   output logic             IRQ
);
   // refuse physical widths the address checks cannot serve
   if (PA_WIDTH < 32 || PA_WIDTH > 64) begin : g_pa_chk
      $error("PA_WIDTH out of range");
   end

   localparam logic [3:0] RA_STATUS = 4'h0;
   localparam logic [3:0] RA_MASK   = 4'h4;
   localparam logic [3:0] RA_PTRLO  = 4'h8;
   localparam logic [3:0] RA_PTRHI  = 4'hC;

   default clocking chk_cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   vmcp_pkg::vmcp_state_e st_r, st_nxt;
   logic [63:0] ptr_r, addr_r;
   logic [2:0]  fault_r;
   logic [1:0]  res_r;
   logic [7:0]  err_r;
   logic [63:0] dst_r;
   logic        dst_we_r, ld_r;
   logic [vmcp_pkg::IRQ_W-1:0] stat_r, mask_r;
   logic [31:0] rdata_r;

   // decode
   wire is_esc   = INSTR_OPCODE == vmcp_pkg::OPC_ESC_GRP;
   wire is_load  = is_esc && INSTR_REG == vmcp_pkg::REG_PTR_LOAD;
   wire is_store = is_esc && INSTR_REG == vmcp_pkg::REG_PTR_STORE;
   wire is_fread = INSTR_OPCODE == vmcp_pkg::OPC_FIELD_RD;
   wire is_lnch  = INSTR_OPCODE == vmcp_pkg::OPC_LAUNCH ||
                   INSTR_OPCODE == vmcp_pkg::OPC_RESUME;
   wire known    = is_load || is_store || is_fread || is_lnch;
   wire mode64   = LONG_MODE_ACTIVE && CS_LONG;
   wire compat   = LONG_MODE_ACTIVE && !CS_LONG;
   wire mode_ud  = !VIRT_OP_ACTIVE || !PROT_ENABLE || V86_MODE ||
                   compat;
   wire reg_ud   = (is_load || is_store) && INSTR_REG_OPND;
   wire priv_bad = CUR_PRIV != 2'h0;

   // memory operand faults, segment errors on the stack segment give stack fault
   wire seg_err  = SEG_LIMIT_ERR || SEG_UNUSABLE ||
                   (mode64 && ADDR_NONCANON);
   wire wr_prot  = SEG_READ_ONLY || SEG_IS_CODE;
   wire rd_prot  = SEG_EXEC_ONLY;
   wire [2:0] seg_flt = SEG_IS_STACK ? vmcp_pkg::FLT_SS
                                     : vmcp_pkg::FLT_GP;
   wire [2:0] mem_flt_rd = (seg_err) ? seg_flt :
                           rd_prot ? vmcp_pkg::FLT_GP :
                           PAGE_ERR ? vmcp_pkg::FLT_PF : vmcp_pkg::FLT_NONE;
   wire [2:0] mem_flt_wr = (seg_err) ? seg_flt :
                           wr_prot ? vmcp_pkg::FLT_GP :
                           PAGE_ERR ? vmcp_pkg::FLT_PF : vmcp_pkg::FLT_NONE;

   // field read operand widths
   assign FIELD_ENC = INSTR_FIELD_ENC[vmcp_pkg::ENC_WIDTH-1:0];
   wire enc_hi_bad = mode64 &&
                     INSTR_FIELD_ENC[63:vmcp_pkg::ENC_WIDTH] != 32'h0;
   wire field_ok   = FIELD_SUPPORTED && !enc_hi_bad;
   wire [63:0] fmask = (FIELD_WIDTH >= 7'd64) ? vmcp_pkg::PTR_INVALID :
                       ((64'h1 << FIELD_WIDTH[5:0]) - 64'h1);
   wire [63:0] fval  = FIELD_DATA & fmask;
   wire [63:0] fdst  = mode64 ? fval : {32'h0, fval[31:0]};

   // pointer load address checks
   wire [63:0] ld_addr  = MEM_RDATA;
   wire        pa_over  = (PA_WIDTH < 64) &&
                          ((ld_addr >> PA_WIDTH) != 64'h0);
   wire        narrow   = BASIC_CAP[vmcp_pkg::CAP_NARROW_BIT] &&
                          ld_addr[63:32] != 32'h0;
   wire        bad_addr = ld_addr[vmcp_pkg::PAGE_BITS-1:0] != 12'h0 ||
                          pa_over || narrow;
   wire        is_enptr = ld_addr == ENABLE_REGION_PTR;

   // issue-time verdict: fault, immediate outcome, or memory phase
   logic [2:0] iflt;
   logic [1:0] ires;
   logic [7:0] ierr;
   logic       imem, idst;
   always_comb begin
      iflt = vmcp_pkg::FLT_NONE;
      ires = vmcp_pkg::RES_OK;
      ierr = vmcp_pkg::ERR_NONE;
      imem = 1'b0;
      idst = 1'b0;
      if (!known || reg_ud || mode_ud) begin
         iflt = vmcp_pkg::FLT_UD;
      end else if (GUEST_ACTIVE) begin
         iflt = vmcp_pkg::FLT_EXIT;
      end else if (priv_bad) begin
         iflt = vmcp_pkg::FLT_GP;
      end else if (is_lnch) begin
         iflt = vmcp_pkg::FLT_UD;  // entry itself is not handled here
      end else if (is_load) begin
         iflt = mem_flt_rd;
         imem = iflt == vmcp_pkg::FLT_NONE;
      end else if (is_store) begin
         iflt = mem_flt_wr;
         imem = iflt == vmcp_pkg::FLT_NONE;
      end else if (!CUR_PTR_VALID) begin
         ires = vmcp_pkg::RES_FAIL_INV;
      end else if (!field_ok) begin
         ires = vmcp_pkg::RES_FAIL_VAL;
         ierr = vmcp_pkg::ERR_UNSUP;
      end else if (INSTR_REG_OPND) begin
         idst = 1'b1;
      end else begin
         iflt = mem_flt_wr;
         imem = iflt == vmcp_pkg::FLT_NONE;
      end
   end

   // state machine
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         vmcp_pkg::VMCP_IDLE:
            if (INSTR_VALID && imem)
               st_nxt = is_load ? vmcp_pkg::VMCP_OPRD : vmcp_pkg::VMCP_WRITE;
            else if (INSTR_VALID)
               st_nxt = vmcp_pkg::VMCP_DONE;
         vmcp_pkg::VMCP_OPRD:
            if (MEM_ACK)
               st_nxt = (bad_addr || is_enptr) ? vmcp_pkg::VMCP_DONE
                                               : vmcp_pkg::VMCP_REVRD;
         vmcp_pkg::VMCP_REVRD, vmcp_pkg::VMCP_WRITE:
            if (MEM_ACK)
               st_nxt = vmcp_pkg::VMCP_DONE;
         vmcp_pkg::VMCP_DONE:
            st_nxt = vmcp_pkg::VMCP_IDLE;
         default:
            st_nxt = vmcp_pkg::VMCP_IDLE;
      endcase
   end

   wire in_oprd  = st_r == vmcp_pkg::VMCP_OPRD;
   wire in_revrd = st_r == vmcp_pkg::VMCP_REVRD;
   wire in_write = st_r == vmcp_pkg::VMCP_WRITE;
   wire issue    = st_r == vmcp_pkg::VMCP_IDLE && INSTR_VALID;
   wire rev_ok   = MEM_RDATA[31:0] == REV_ID;
   wire ptr_take = in_revrd && MEM_ACK && rev_ok;

   assign MEM_REQ   = in_oprd || in_revrd || in_write;
   assign MEM_KIND  = in_oprd  ? vmcp_pkg::MEM_RD64 :
                      in_revrd ? vmcp_pkg::MEM_RD32 :
                      ld_r     ? vmcp_pkg::MEM_WR64 : vmcp_pkg::MEM_WRDST;
   assign MEM_WDATA = ld_r ? ptr_r : dst_r;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= vmcp_pkg::VMCP_IDLE;
         ptr_r <= vmcp_pkg::PTR_INVALID;
      end else begin
         st_r <= st_nxt;
         if (ptr_take)
            ptr_r <= addr_r;
      end
   end

   // per-instruction outcome registers
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         fault_r <= vmcp_pkg::FLT_NONE;
         res_r <= vmcp_pkg::RES_OK;
         err_r <= vmcp_pkg::ERR_NONE;
         dst_r <= 64'h0;
         dst_we_r <= 1'b0;
         addr_r <= 64'h0;
         ld_r <= 1'b0;
      end else if (issue) begin
         fault_r <= iflt;
         res_r <= ires;
         err_r <= ierr;
         dst_r <= is_store ? ptr_r : fdst;
         dst_we_r <= idst;
         ld_r <= is_store;
      end else if (in_oprd && MEM_ACK) begin
         addr_r <= ld_addr;
         if (bad_addr) begin
            res_r <= vmcp_pkg::RES_FAIL_VAL;
            err_r <= vmcp_pkg::ERR_LD_ADDR;
         end else if (is_enptr) begin
            res_r <= vmcp_pkg::RES_FAIL_VAL;
            err_r <= vmcp_pkg::ERR_LD_ENPTR;
         end
      end else if (in_revrd && MEM_ACK && !rev_ok) begin
         res_r <= vmcp_pkg::RES_FAIL_VAL;
         err_r <= vmcp_pkg::ERR_LD_REV;
      end
   end

   assign DONE          = st_r == vmcp_pkg::VMCP_DONE;
   assign FAULT         = fault_r;
   assign RESULT        = res_r;
   assign ERR_NUM       = err_r;
   assign DEST_DATA     = dst_r;
   assign DEST_WE       = DONE && dst_we_r;
   assign CUR_PTR       = ptr_r;
   assign CUR_PTR_VALID = ptr_r != vmcp_pkg::PTR_INVALID;

   // interrupt status: set wins over write-one clear
   wire [vmcp_pkg::IRQ_W-1:0] ev;
   assign ev[vmcp_pkg::IRQ_DONE]  = DONE && fault_r == vmcp_pkg::FLT_NONE &&
                                    res_r == vmcp_pkg::RES_OK;
   assign ev[vmcp_pkg::IRQ_FAULT] = DONE && fault_r != vmcp_pkg::FLT_NONE;
   assign ev[vmcp_pkg::IRQ_FAIL]  = DONE && fault_r == vmcp_pkg::FLT_NONE &&
                                    res_r != vmcp_pkg::RES_OK;
   wire wr_stat = REG_WR && REG_ADDR == RA_STATUS;
   wire wr_mask = REG_WR && REG_ADDR == RA_MASK;
   wire [31:0] rd_mux =
      REG_ADDR == RA_STATUS ? {29'h0, stat_r} :
      REG_ADDR == RA_MASK   ? {29'h0, mask_r} :
      REG_ADDR == RA_PTRLO  ? ptr_r[31:0] :
      REG_ADDR == RA_PTRHI  ? ptr_r[63:32] : 32'h0;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         stat_r <= '0;
         mask_r <= '0;
         rdata_r <= 32'h0;
      end else begin
         stat_r <= (stat_r & ~(wr_stat ? REG_WDATA[vmcp_pkg::IRQ_W-1:0]
                                       : '0)) | ev;
         if (wr_mask)
            mask_r <= REG_WDATA[vmcp_pkg::IRQ_W-1:0];
         rdata_r <= REG_RD ? rd_mux : 32'h0;
      end
   end
   assign REG_RDATA = rdata_r;
   assign IRQ       = |(stat_r & mask_r);

   // checks: the two acknowledged reads of a pointer load, and the fault, store and field-read outcomes
   sequence s_opnd_ack;
      in_oprd && MEM_ACK;
   endsequence
   sequence s_rev_ack;
      in_revrd && MEM_ACK;
   endsequence
   a_revfail_keeps_ptr: assert property (
      s_rev_ack ##0 !rev_ok |=> $stable(ptr_r) && DONE
      && ERR_NUM == vmcp_pkg::ERR_LD_REV)
      else $error("revision mismatch must fail and keep pointer");
   a_badaddr_fail: assert property (
      s_opnd_ack ##0 bad_addr |=> DONE && $stable(ptr_r)
      && ERR_NUM == vmcp_pkg::ERR_LD_ADDR)
      else $error("bad load address must fail at once");
   a_enptr_fail: assert property (
      s_opnd_ack ##0 !bad_addr && is_enptr |=> DONE
      && RESULT == vmcp_pkg::RES_FAIL_VAL
      && ERR_NUM == vmcp_pkg::ERR_LD_ENPTR)
      else $error("enable pointer load must fail");
   a_load_ok: assert property (
      s_rev_ack ##0 rev_ok |=> CUR_PTR == $past(addr_r) && DONE
      && RESULT == vmcp_pkg::RES_OK)
      else $error("good load must set pointer and succeed");
   a_mode_ud: assert property (
      issue && mode_ud |=> DONE && FAULT == vmcp_pkg::FLT_UD)
      else $error("mode violation must give invalid opcode");
   a_priv_gp: assert property (
      issue && known && !reg_ud && !mode_ud && !GUEST_ACTIVE && priv_bad
      |=> DONE && FAULT == vmcp_pkg::FLT_GP)
      else $error("nonzero privilege must fault");
   a_fread_invalid: assert property (
      issue && is_fread && !mode_ud && !GUEST_ACTIVE && !priv_bad
      && !CUR_PTR_VALID |=> DONE && !MEM_REQ
      && RESULT == vmcp_pkg::RES_FAIL_INV)
      else $error("invalid pointer read must fail without memory");
   a_store_data: assert property (
      in_write && ld_r |-> MEM_WDATA == CUR_PTR
      && MEM_KIND == vmcp_pkg::MEM_WR64)
      else $error("store must write current pointer");
   a_dest_width: assert property (
      issue && is_fread && !mode64 |=> dst_r[63:32] == 32'h0)
      else $error("narrow destination must clear high half");
endmodule

// File: tb/vmcp_mem_model.sv
// memory model answering operand, revision and store accesses of the unit
`timescale 1ns/1ps
module vmcp_mem_model (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // memory port
   input  wire logic        MEM_REQ,
   input  wire logic [1:0]  MEM_KIND,
   input  wire logic [63:0] MEM_WDATA,
   output logic             MEM_ACK,
   output logic [63:0]      MEM_RDATA,
   // contents and pacing
   input  wire logic [63:0] OPND,
   input  wire logic [31:0] REV,
   input  wire logic [3:0]  DLY,
   output logic [63:0]      WR_DATA,
   output logic [7:0]       N_REQ
);
   logic [3:0]  cnt_r;
   logic [63:0] last_r;
   logic [63:0] rd_word;
   assign MEM_ACK = MEM_REQ && (cnt_r >= DLY);
   // upper half is no part of the revision word, so it keeps changing
   assign rd_word = (MEM_KIND == vmcp_pkg::MEM_RD64) ? OPND
                                                     : {~last_r[63:32], REV};
   // a released data bus shows the inverse of its last word
   assign MEM_RDATA = MEM_ACK ? rd_word : ~last_r;
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_r   <= 4'h0;
         last_r  <= 64'h0;
         WR_DATA <= 64'h0;
         N_REQ   <= 8'h0;
      end else begin
         cnt_r <= (MEM_REQ && !MEM_ACK) ? cnt_r + 4'h1 : 4'h0;
         if (MEM_ACK) begin
            last_r <= rd_word;
            N_REQ  <= N_REQ + 8'h1;
         end
         if (MEM_ACK && MEM_KIND[1])
            WR_DATA <= MEM_WDATA;
      end
   end
endmodule

// File: tb/tb_top.sv
// self-checking bench of the control-pointer instruction unit
`timescale 1ns/1ps
module tb_top;
   localparam int          PAW = 40;
   localparam logic [31:0] REV = 32'h0000_0005; // arbitrary value
   localparam logic [7:0]  M64 = 8'hAC;
   localparam logic [7:0]  M32 = 8'hA0;
   localparam logic [63:0] P1  = 64'h0000_0012_3456_7000;
   localparam logic [2:0]  NF = vmcp_pkg::FLT_NONE, UD = vmcp_pkg::FLT_UD;
   localparam logic [2:0]  GP = vmcp_pkg::FLT_GP, SS = vmcp_pkg::FLT_SS;
   localparam logic [2:0]  PF = vmcp_pkg::FLT_PF, EX = vmcp_pkg::FLT_EXIT;
   // mode bits: virt, guest, prot, v86, lma, cs long, privilege
   localparam logic [7:0]  MS [8] = '{8'h2C, 8'h8C, 8'hBC, 8'hA8, 8'h6F,
                                      8'hEC, 8'hEF, 8'hAD};
   localparam logic [2:0]  MF [8] = '{UD, UD, UD, UD, UD, EX, EX, GP};
   localparam logic [7:0]  OP [5] = '{8'hC7, 8'hC7, 8'h78, 8'hC2, 8'hC3};
   localparam logic [2:0]  OR [5] = '{3'h6, 3'h7, 3'h0, 3'h0, 3'h0};
   // segment bits: limit, unusable, stack, exec-only, ro, code, noncanon, page
   localparam logic [7:0]  SG [10] = '{8'h80, 8'h40, 8'hA0, 8'h60, 8'h10,
                                       8'h01, 8'h02, 8'h22, 8'h08, 8'h04};
   localparam logic [2:0]  SF [10] = '{GP, GP, SS, SS, GP, PF, GP, SS, GP, GP};
   localparam logic [63:0] BA [4] = '{64'h0000_0000_0010_0800,
      64'h0000_0100_0000_0000, 64'h0000_0001_0000_0000, 64'h0000_0000_0000_3000};
   localparam logic [7:0]  BE [4] = '{8'h09, 8'h09, 8'h09, 8'h0A};
   logic        SYS_CLK = 1'b0;
   logic        RSTN = 1'b0;
   logic        vld = 1'b0, rop = 1'b0, fsup = 1'b0, rwr = 1'b0, rrd = 1'b0;
   logic [7:0]  opc = 8'h00, md = M64, sg = 8'h00;
   logic [2:0]  rg = 3'h0;
   logic [63:0] enc = 64'h0, fdat = 64'h0, cap = 64'h0, opnd = P1;
   logic [63:0] enp = 64'h0000_0000_0000_3000;
   logic [6:0]  fw = 7'h40;
   logic [3:0]  dly = 4'h0, ra = 4'h0;
   logic [31:0] rwd = 32'h0, rv = REV;
   logic [31:0] fenc, rdat;
   logic        mreq, mack, done, dwe, pv, irq, we_s;
   logic [1:0]  mkind, res;
   logic [63:0] mwd, mrd, dd, ptr, wrd, dd_s;
   logic [2:0]  flt;
   logic [7:0]  err, nreq;
   int          miscompares = 0, n_compared = 0;
   always #2.5 SYS_CLK = ~SYS_CLK;
   vmcp_unit #(.PA_WIDTH(PAW), .REV_ID(REV)) vmcp_unit_i (.SYS_CLK(SYS_CLK),
      .RSTN(RSTN), .INSTR_VALID(vld), .INSTR_OPCODE(opc), .INSTR_REG(rg),
      .INSTR_REG_OPND(rop), .INSTR_FIELD_ENC(enc), .VIRT_OP_ACTIVE(md[7]),
      .GUEST_ACTIVE(md[6]), .PROT_ENABLE(md[5]), .V86_MODE(md[4]),
      .LONG_MODE_ACTIVE(md[3]), .CS_LONG(md[2]), .CUR_PRIV(md[1:0]),
      .BASIC_CAP(cap), .ENABLE_REGION_PTR(enp), .SEG_LIMIT_ERR(sg[7]),
      .SEG_UNUSABLE(sg[6]), .SEG_IS_STACK(sg[5]), .SEG_EXEC_ONLY(sg[4]),
      .SEG_READ_ONLY(sg[3]), .SEG_IS_CODE(sg[2]), .ADDR_NONCANON(sg[1]),
      .PAGE_ERR(sg[0]), .FIELD_ENC(fenc), .FIELD_SUPPORTED(fsup),
      .FIELD_DATA(fdat), .FIELD_WIDTH(fw), .MEM_REQ(mreq), .MEM_KIND(mkind),
      .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd), .DONE(done),
      .FAULT(flt), .RESULT(res), .ERR_NUM(err), .DEST_DATA(dd),
      .DEST_WE(dwe), .CUR_PTR(ptr), .CUR_PTR_VALID(pv), .REG_ADDR(ra),
      .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat),
      .IRQ(irq));
   vmcp_mem_model vmcp_mem_model_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
      .MEM_REQ(mreq), .MEM_KIND(mkind), .MEM_WDATA(mwd), .MEM_ACK(mack),
      .MEM_RDATA(mrd), .OPND(opnd), .REV(rv), .DLY(dly), .WR_DATA(wrd),
      .N_REQ(nreq));
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_d(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_f(input logic [2:0] e);
      chk_d({61'h0, flt}, {61'h0, e});
   endtask
   task automatic chk_o(input logic [1:0] r, input logic [7:0] e);
      chk_d({54'h0, res, err}, {54'h0, r, e});
   endtask
   task automatic issue(input logic [7:0] o, input logic [2:0] r,
                        input logic ro, input logic [7:0] m, input logic [7:0] s);
      @(posedge SYS_CLK);
      opc <= o;
      rg  <= r;
      rop <= ro;
      md  <= m;
      sg  <= s;
      vld <= 1'b1;
      @(posedge SYS_CLK);
      vld <= 1'b0;
      for (int i = 0; i < 40 && done !== 1'b1; i++)
         @(negedge SYS_CLK);
      we_s = dwe;
      dd_s = dd;
      chk_d({63'h0, done}, 64'h1);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ra  <= a;
      rwd <= d;
      rwr <= 1'b1;
      @(posedge SYS_CLK);
      rwr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge SYS_CLK);
      ra  <= a;
      rrd <= 1'b1;
      @(posedge SYS_CLK);
      rrd <= 1'b0;
      @(negedge SYS_CLK);
      chk_d({32'h0, rdat}, {32'h0, e});
   endtask
   task automatic t_inval();
      chk_d({ptr[63:1], pv}, {vmcp_pkg::PTR_INVALID[63:1], 1'b0});
      @(posedge SYS_CLK);
      fsup <= 1'b1;
      issue(8'h78, 3'h0, 1'b0, M64, 8'h01);
      chk_d({62'h0, res}, {62'h0, vmcp_pkg::RES_FAIL_INV});
      chk_d({56'h0, nreq}, 64'h0);
      chk_f(NF);
      issue(8'hC7, 3'h7, 1'b0, M64, 8'h00);
      chk_d(wrd, vmcp_pkg::PTR_INVALID);
   endtask
   task automatic t_modes();
      for (int k = 0; k < 5; k++)
         for (int j = 0; j < 8; j++) begin
            issue(OP[k], OR[k], 1'b0, MS[j], 8'h00);
            chk_f(MF[j]);
         end
      issue(8'hC7, 3'h6, 1'b1, M64, 8'h00);
      chk_f(UD);
      issue(8'hC7, 3'h7, 1'b1, M64, 8'h00);
      chk_f(UD);
   endtask
   task automatic t_load();
      @(posedge SYS_CLK);
      dly <= 4'h3;
      issue(8'hC7, 3'h6, 1'b0, M64, 8'h00);
      chk_o(vmcp_pkg::RES_OK, vmcp_pkg::ERR_NONE);
      chk_d({ptr[63:1], pv}, {P1[63:1], 1'b1});
      issue(8'hC7, 3'h7, 1'b0, M64, 8'h00);
      chk_d(wrd, P1);
      @(posedge SYS_CLK);
      dly <= 4'h0;
      cap <= 64'h0001_0000_0000_0000;
      for (int k = 0; k < 5; k++) begin
         @(posedge SYS_CLK);
         opnd <= (k < 4) ? BA[k] : 64'h0000_0000_0000_5000;
         rv   <= (k < 4) ? REV : ~REV;
         issue(8'hC7, 3'h6, 1'b0, M64, 8'h00);
         chk_o(vmcp_pkg::RES_FAIL_VAL, (k < 4) ? BE[k] : 8'h0B);
         chk_d(ptr, P1);
      end
      @(posedge SYS_CLK);
      rv  <= REV;
      cap <= 64'h0;
      for (int j = 0; j < 10; j++) begin
         issue(8'hC7, (j < 8) ? 3'h6 : 3'h7, 1'b0, M64, SG[j]);
         chk_f(SF[j]);
      end
   endtask
   task automatic t_field();
      @(posedge SYS_CLK);
      fdat <= 64'h1122_3344_5566_7788;
      enc  <= 64'h0000_0001_0000_4002;
      issue(8'h78, 3'h0, 1'b1, M32, 8'h00);
      chk_o(vmcp_pkg::RES_OK, vmcp_pkg::ERR_NONE);
      chk_d({we_s, fenc, dd_s[62:32]}, {1'b1, 32'h0000_4002, 31'h0});
      chk_d(dd_s, 64'h0000_0000_5566_7788);
      issue(8'h78, 3'h0, 1'b1, M64, 8'h00);
      chk_o(vmcp_pkg::RES_FAIL_VAL, vmcp_pkg::ERR_UNSUP);
      @(posedge SYS_CLK);
      enc <= 64'h0000_0000_0000_4002;
      issue(8'h78, 3'h0, 1'b1, M64, 8'h00);
      chk_d(dd_s, 64'h1122_3344_5566_7788);
      @(posedge SYS_CLK);
      fw   <= 7'h10;
      fdat <= 64'hFFFF_FFFF_FFFF_ABCD;
      issue(8'h78, 3'h0, 1'b1, M64, 8'h00);
      chk_d(dd_s, 64'h0000_0000_0000_ABCD);
      @(posedge SYS_CLK);
      fw <= 7'h40;
      issue(8'h78, 3'h0, 1'b0, M64, 8'h00);
      chk_d({we_s, wrd[62:0]}, {1'b0, 63'h7FFF_FFFF_FFFF_ABCD});
      @(posedge SYS_CLK);
      fsup <= 1'b0;
      issue(8'h78, 3'h0, 1'b0, M64, 8'h01);
      chk_o(vmcp_pkg::RES_FAIL_VAL, vmcp_pkg::ERR_UNSUP);
      chk_f(NF);
      @(posedge SYS_CLK);
      fsup <= 1'b1;
      issue(8'h78, 3'h0, 1'b0, M64, 8'h01);
      chk_f(PF);
   endtask
   task automatic t_regs();
      rd(4'h0, 32'h0000_0007);
      wr(4'h0, 32'h0000_0007);
      rd(4'h0, 32'h0);
      issue(8'hC7, 3'h7, 1'b0, M64, 8'h00);
      rd(4'h0, 32'h0000_0001);
      chk_d({63'h0, irq}, 64'h0);
      wr(4'h4, 32'h0000_0001);
      repeat (2) @(negedge SYS_CLK);
      chk_d({63'h0, irq}, 64'h1);
      rd(4'h4, 32'h0000_0001);
      wr(4'hC, 32'h0);
      rd(4'h8, P1[31:0]);
      rd(4'hC, P1[63:32]);
      rd(4'h2, 32'h0);
      wr(4'h0, 32'h0000_0001);
      repeat (2) @(negedge SYS_CLK);
      chk_d({63'h0, irq}, 64'h0);
      wr(4'h4, 32'h0);
   endtask
   initial begin
      #100000;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      t_inval();
      t_modes();
      t_load();
      t_field();
      t_regs();
      close_out();
   end
endmodule
